// >>> inc/ext_bus_pkg.sv
// Summary of operation
// - Code fetches strobe only the program store.
// - Data moves use separate read/write strobes.
// - Code fetch always drives full 16-bit address.
// - Pointer form 16-bit, indirect form 8-bit.
// - Port 0 drives address, then data.
// - Every access refills port 0 latch with ones.
// - Wide access holds high address on port 2.
// - Narrow access keeps port 2 latch on pins.
// - Address ones get strong pullup whole cycle.
// - Write data surrounds the write strobe.
// - Read byte captured before strobe release.
// - Cleared enable bit never gates latch strobe; internal fetches are not taken.
// - Data moves always latch; external code ignores bit.
// - Data cycle six periods, fetch three.
// - Program strobe only for external fetches.
package ext_bus_pkg;

	// -----------------------------------------------------------------
	// Cycle counts, one clock is one oscillator period.
	// -----------------------------------------------------------------
	localparam int FETCH_CYCLES        = 3;
	localparam int DATA_CYCLES         = 6;
	localparam int FETCH_STROBE_CYCLES = FETCH_CYCLES - 1;
	localparam int DATA_STROBE_CYCLES  = DATA_CYCLES - 3;

	// -----------------------------------------------------------------
	// Values after reset and fixed fills.
	// -----------------------------------------------------------------
	localparam logic [7:0] P0_LATCH_FILL = 8'hff;
	localparam logic [7:0] BYTE_ZERO     = 8'h00;
	localparam logic       LSE_RESET     = 1'b1;

	typedef enum logic [1:0] {KIND_FETCH, KIND_READ, KIND_WRITE} kind_e;

	typedef enum logic [2:0] {ST_IDLE, ST_LATCH, ST_SETUP, ST_STROBE, ST_HOLD} bus_state_e;

endpackage : ext_bus_pkg

// >>> verilog/sync_two_ff.sv
`timescale 1ns/1ps
`default_nettype none

module sync_two_ff #(
	parameter int               WIDTH       = 1,
	parameter logic [WIDTH-1:0] RESET_LEVEL = '0
) (
	input  wire logic             clk,
	input  wire logic             sys_rst,
	input  wire logic [WIDTH-1:0] async_in,
	output var  logic [WIDTH-1:0] sync_out
);
	import ext_bus_pkg::*;

	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} sync_s;

	sync_s cur_ff;
	sync_s nxt_ff;

	if (WIDTH < 1)
	begin : g_chk
		$error("sync_two_ff: WIDTH must be at least 1.");
	end

	// The first stage feeds only the second, so metastability never reaches logic.
	always_comb
	begin
		nxt_ff.meta   = async_in;
		nxt_ff.stable = cur_ff.meta;
	end

	// Both stages reset to the pin's idle level, so no false level reaches the logic while they refill.
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			cur_ff <= '{meta: RESET_LEVEL, stable: RESET_LEVEL};
		else
			cur_ff <= nxt_ff;
	end

	assign sync_out = cur_ff.stable;

endmodule : sync_two_ff
`default_nettype wire

// >>> verilog/ext_mem_bus.sv
`timescale 1ns/1ps
`default_nettype none

module ext_mem_bus (
	input  wire logic                 clk,
	input  wire logic                 sys_rst,
	// Core side.
	input  wire logic                 req_valid,
	input  wire ext_bus_pkg::kind_e   req_kind,
	input  wire logic                 req_data_pointer,
	input  wire logic [15:0]          req_addr,
	input  wire logic [7:0]           req_wdata,
	output var  logic                 req_ready,
	output var  logic                 rsp_valid,
	output var  logic [7:0]           rsp_data,
	input  wire logic [7:0]           p2_latch,
	output var  logic                 p0_latch_fill,
	input  wire logic                 latch_strobe_enable,
	// Pins.
	input  wire logic                 external_code_select_n,
	input  wire logic [7:0]           p0_in,
	output var  logic [7:0]           p0_out,
	output var  logic                 p0_oe,
	output var  logic [7:0]           p2_out,
	output var  logic [7:0]           p2_strong_pullup,
	output var  logic                 address_latch_strobe,
	output var  logic                 program_store_strobe_n,
	output var  logic                 data_read_strobe_n,
	output var  logic                 data_write_strobe_n
);
	import ext_bus_pkg::*;

	typedef struct packed {
		bus_state_e  state;
		kind_e       kind;
		logic        wide;
		logic [1:0]  cnt;
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic        lse;
		logic        ale;
		logic        program_store_strobe_n_n;
		logic        rd_n;
		logic        wr_n;
		logic [7:0]  p0_out;
		logic        p0_oe;
		logic [7:0]  p2_out;
		logic [7:0]  p2_strong;
		logic        p0_fill;
		logic        ready;
		logic        rsp_valid;
		logic [7:0]  rsp_data;
		logic        fetch_cap;
	} bus_s;

	bus_s       cur_ff;
	bus_s       nxt_ff;
	logic [7:0] p0_sync;
	logic       ecs_n_sync;
	logic       ext_code;
	logic       take;
	logic [1:0] last_cnt;

	// -----------------------------------------------------------------
	// Pin synchronisers.
	// -----------------------------------------------------------------
	sync_two_ff #(.WIDTH(8)) u_p0_sync (
		.clk      (clk),
		.sys_rst  (sys_rst),
		.async_in (p0_in),
		.sync_out (p0_sync)
	);

	// Resets to internal code, so no fetch is taken before the pin has been seen.
	sync_two_ff #(.WIDTH(1), .RESET_LEVEL(1'b1)) u_ecs_sync (
		.clk      (clk),
		.sys_rst  (sys_rst),
		.async_in (external_code_select_n),
		.sync_out (ecs_n_sync)
	);

	// -----------------------------------------------------------------
	// Sequencer.
	// -----------------------------------------------------------------
	assign ext_code = ~ecs_n_sync;
	// Internal code fetches are dropped here, so the program strobe never moves for them.
	assign take     = (cur_ff.state == ST_IDLE) && req_valid && ((req_kind != KIND_FETCH) || ext_code);
	assign last_cnt = (cur_ff.kind == KIND_FETCH) ? 2'(FETCH_STROBE_CYCLES - 1) : 2'(DATA_STROBE_CYCLES - 1);

	// Next state first, then every pin value is decoded from that next state so outputs are flops.
	always_comb
	begin
		nxt_ff           = cur_ff;
		nxt_ff.lse       = latch_strobe_enable;
		nxt_ff.p0_fill   = 1'b0;
		nxt_ff.rsp_valid = 1'b0;
		nxt_ff.fetch_cap = 1'b0;
		case (cur_ff.state)
			ST_IDLE:
			begin
				if (take)
				begin
					nxt_ff.state   = ST_LATCH;
					nxt_ff.kind    = req_kind;
					nxt_ff.wide    = (req_kind == KIND_FETCH) || req_data_pointer;
					nxt_ff.addr    = req_addr;
					nxt_ff.wdata   = req_wdata;
					nxt_ff.cnt     = 2'd0;
					nxt_ff.p0_fill = 1'b1;
				end
			end
			ST_LATCH:
			begin
				nxt_ff.state = (cur_ff.kind == KIND_FETCH) ? ST_STROBE : ST_SETUP;
			end
			ST_SETUP:
			begin
				nxt_ff.state = ST_STROBE;
			end
			ST_STROBE:
			begin
				if (cur_ff.cnt == last_cnt)
				begin
					nxt_ff.cnt = 2'd0;
					// Sampled while the strobe is still low; memory data must be settled early.
					if (cur_ff.kind == KIND_READ)
					begin
						nxt_ff.rsp_valid = 1'b1;
						nxt_ff.rsp_data  = p0_sync;
					end
					// The fetch strobe is too short for the synchroniser; its byte is taken one period later.
					nxt_ff.fetch_cap = (cur_ff.kind == KIND_FETCH);
					nxt_ff.state = (cur_ff.kind == KIND_FETCH) ? ST_IDLE : ST_HOLD;
					if (cur_ff.kind == KIND_WRITE)
						nxt_ff.rsp_valid = 1'b1;
				end
				else
					nxt_ff.cnt = cur_ff.cnt + 2'd1;
			end
			ST_HOLD:
			begin
				nxt_ff.state = ST_IDLE;
			end
			default:
			begin
				nxt_ff.state = ST_IDLE;
			end
		endcase

		// The first stage sampled the pin while the program strobe was still low.
		if (cur_ff.fetch_cap)
		begin
			nxt_ff.rsp_valid = 1'b1;
			nxt_ff.rsp_data  = p0_sync;
		end

		// Pin decode from the next state.
		nxt_ff.ready     = (nxt_ff.state == ST_IDLE);
		// With external code the enable bit is ignored; data moves always latch.
		nxt_ff.ale       = (nxt_ff.state == ST_LATCH) &&
			(nxt_ff.lse || ext_code || (nxt_ff.kind != KIND_FETCH));
		nxt_ff.program_store_strobe_n_n    = !((nxt_ff.state == ST_STROBE) && (nxt_ff.kind == KIND_FETCH));
		nxt_ff.rd_n      = !((nxt_ff.state == ST_STROBE) && (nxt_ff.kind == KIND_READ));
		nxt_ff.wr_n      = !((nxt_ff.state == ST_STROBE) && (nxt_ff.kind == KIND_WRITE));
		nxt_ff.p0_oe     = (nxt_ff.state == ST_LATCH) ||
			((nxt_ff.kind == KIND_WRITE) && (nxt_ff.state != ST_IDLE));
		nxt_ff.p0_out    = (nxt_ff.state == ST_LATCH) ? nxt_ff.addr[7:0] :
			((nxt_ff.p0_oe) ? nxt_ff.wdata : BYTE_ZERO);
		if (nxt_ff.state == ST_IDLE)
		begin
			nxt_ff.p2_out    = p2_latch;
			nxt_ff.p2_strong = BYTE_ZERO;
		end
		else
		begin
			nxt_ff.p2_out    = nxt_ff.wide ? nxt_ff.addr[15:8] : p2_latch;
			nxt_ff.p2_strong = nxt_ff.p2_out;
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			cur_ff           <= '0;
			cur_ff.state     <= ST_IDLE;
			cur_ff.kind      <= KIND_FETCH;
			cur_ff.lse       <= LSE_RESET;
			cur_ff.program_store_strobe_n_n    <= 1'b1;
			cur_ff.rd_n      <= 1'b1;
			cur_ff.wr_n      <= 1'b1;
			cur_ff.ready     <= 1'b1;
		end
		else
			cur_ff <= nxt_ff;
	end

	assign req_ready              = cur_ff.ready;
	assign rsp_valid              = cur_ff.rsp_valid;
	assign rsp_data               = cur_ff.rsp_data;
	assign p0_latch_fill          = cur_ff.p0_fill;
	assign p0_out                 = cur_ff.p0_out;
	assign p0_oe                  = cur_ff.p0_oe;
	assign p2_out                 = cur_ff.p2_out;
	assign p2_strong_pullup       = cur_ff.p2_strong;
	assign address_latch_strobe   = cur_ff.ale;
	assign program_store_strobe_n = cur_ff.program_store_strobe_n_n;
	assign data_read_strobe_n     = cur_ff.rd_n;
	assign data_write_strobe_n    = cur_ff.wr_n;

	// -----------------------------------------------------------------
	// Checks.
	// -----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	a_strobe_exclusive: assert property (
		!(!program_store_strobe_n && (!data_read_strobe_n || !data_write_strobe_n)))
		else $error("Program and data strobes active together.");

	a_program_store_strobe_n_only_fetch: assert property (
		!program_store_strobe_n |-> (cur_ff.kind == KIND_FETCH) && $past(!ecs_n_sync, 3))
		else $error("Program strobe outside an external fetch.");

	a_fetch_length: assert property (
		$fell(program_store_strobe_n) |-> !program_store_strobe_n [*2] ##1 program_store_strobe_n)
		else $error("Program strobe not two cycles long.");

	a_read_length: assert property (
		$fell(data_read_strobe_n) |-> !data_read_strobe_n [*3] ##1 data_read_strobe_n ##1 req_ready)
		else $error("Read strobe not three cycles long.");

	a_write_setup: assert property (
		$fell(data_write_strobe_n) |-> $past(p0_oe) && (p0_out == $past(p0_out)))
		else $error("Write data not set up before strobe.");

	a_write_hold: assert property (
		$rose(data_write_strobe_n) |-> p0_oe && $stable(p0_out))
		else $error("Write data not held after strobe.");

	a_read_capture: assert property (
		$rose(data_read_strobe_n) |-> rsp_valid && (rsp_data == $past(p0_sync, 1)))
		else $error("Read byte not captured at strobe end.");

	a_fetch_capture: assert property (
		$rose(program_store_strobe_n) |-> ##1 rsp_valid && (rsp_data == $past(p0_sync, 1)))
		else $error("Fetch byte not captured after strobe.");

	a_fill_start: assert property (
		p0_latch_fill |-> (cur_ff.state == ST_LATCH) && !req_ready)
		else $error("Port 0 fill not at access start.");

	a_ale_gate: assert property (
		address_latch_strobe && (cur_ff.kind == KIND_FETCH) |-> cur_ff.lse || $past(!ecs_n_sync))
		else $error("Latch strobe not gated off.");

	a_p2_hold: assert property (
		(cur_ff.state != ST_IDLE) && cur_ff.wide |-> (p2_out == cur_ff.addr[15:8]) && (p2_strong_pullup == p2_out))
		else $error("High address not held on port 2.");

endmodule : ext_mem_bus
`default_nettype wire

// >>> bench/ext_memory_model.sv
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------------------------
// External code and data memory behind the multiplexed bus.
// ---------------------------------------------------------------
module ext_memory_model (
	input  wire logic       clk,
	input  wire logic [7:0] p0_out,
	input  wire logic       p0_oe,
	input  wire logic [7:0] p2_out,
	input  wire logic       address_latch_strobe,
	input  wire logic       program_store_strobe_n,
	input  wire logic       data_read_strobe_n,
	input  wire logic       data_write_strobe_n,
	output var  logic [7:0] p0_in
);
	logic [7:0] lo_addr;
	logic [7:0] last;
	logic [7:0] dmem [logic [15:0]];

	// The low byte follows port 0 while the strobe is high, so its fall freezes it.
	always @(posedge clk)
	begin
		if (address_latch_strobe) lo_addr <= p0_out;
		if (!data_write_strobe_n && p0_oe) dmem[{p2_out, lo_addr}] = p0_out;
		last <= p0_in;
	end

	// Data only under a strobe; a released bus shows the inverse of the last byte.
	always @*
	begin
		if (!program_store_strobe_n) p0_in = lo_addr ^ p2_out ^ 8'h3c;
		else if (!data_read_strobe_n && dmem.exists({p2_out, lo_addr})) p0_in = dmem[{p2_out, lo_addr}];
		else if (!data_read_strobe_n) p0_in = lo_addr + p2_out;
		else p0_in = ~last;
	end
endmodule : ext_memory_model

`default_nettype wire

// >>> bench/tb_ext_mem_bus.sv
`timescale 1ns/1ps
`default_nettype none

module tb_ext_mem_bus;
	import ext_bus_pkg::*;
	logic        clk, sys_rst, req_valid, req_data_pointer, latch_strobe_enable, external_code_select_n;
	kind_e       req_kind;
	logic [15:0] req_addr;
	logic [7:0]  req_wdata, p2_latch, p0_in, rsp_data, p0_out, p2_out, p2_strong_pullup;
	logic        req_ready, rsp_valid, p0_latch_fill, p0_oe, ale, program_store_strobe_n_n, rd_n, wr_n;
	int          n_errors, num_checks, seed, r;
	logic [7:0]  ref_mem [logic [15:0]];

	ext_mem_bus i_ext_mem_bus (.clk(clk), .sys_rst(sys_rst), .req_valid(req_valid), .req_kind(req_kind),
		.req_data_pointer(req_data_pointer), .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data), .p2_latch(p2_latch), .p0_latch_fill(p0_latch_fill),
		.latch_strobe_enable(latch_strobe_enable), .external_code_select_n(external_code_select_n),
		.p0_in(p0_in), .p0_out(p0_out), .p0_oe(p0_oe), .p2_out(p2_out), .p2_strong_pullup(p2_strong_pullup),
		.address_latch_strobe(ale), .program_store_strobe_n(program_store_strobe_n_n), .data_read_strobe_n(rd_n),
		.data_write_strobe_n(wr_n));
	ext_memory_model i_ext_memory_model (.clk(clk), .p0_out(p0_out), .p0_oe(p0_oe), .p2_out(p2_out),
		.address_latch_strobe(ale), .program_store_strobe_n(program_store_strobe_n_n), .data_read_strobe_n(rd_n),
		.data_write_strobe_n(wr_n), .p0_in(p0_in));

	// ---------------------------------------------------------------
	// Comparisons and the verdict.
	// ---------------------------------------------------------------
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk8

	task automatic chkc(input logic [31:0] got, input logic [31:0] exp);
		chk8(8'(got), 8'(exp));
	endtask : chkc

	task automatic complete_run;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : complete_run

	// One bus cycle, watched at every falling edge until its answer.
	task automatic do_op(input kind_e k, input logic dp, input logic [15:0] a, input logic [7:0] wd);
		int          cyc;
		logic [7:0]  n_ale, n_ps, n_rd, n_wr, n_fill;
		logic [15:0] ea;
		logic [7:0]  exp;
		cyc = 0; n_ale = 0; n_ps = 0; n_rd = 0; n_wr = 0; n_fill = 0;
		ea = (k == KIND_FETCH || dp) ? a : {p2_latch, a[7:0]};
		exp = (k == KIND_FETCH) ? (ea[7:0] ^ ea[15:8] ^ 8'h3c) : ref_mem.exists(ea) ? ref_mem[ea] : ea[7:0] + ea[15:8];
		req_valid = 1'b1; req_kind = k; req_data_pointer = dp; req_addr = a; req_wdata = wd;
		do
		begin
			@(negedge clk);
			req_valid = 1'b0;
			cyc++;
			n_ale += ale; n_ps += !program_store_strobe_n_n; n_rd += !rd_n; n_wr += !wr_n; n_fill += p0_latch_fill;
			if (cyc == 1) chk8(p0_oe ? p0_out : 8'hxx, ea[7:0]);
			if (!program_store_strobe_n_n || !rd_n || !wr_n)
			begin
				chk8(p2_out, ea[15:8]);
				chk8(p2_strong_pullup, ea[15:8]);
				chk8({7'h00, !program_store_strobe_n_n && !(rd_n && wr_n)}, 8'h00);
			end
			if (!wr_n || (k == KIND_WRITE && rsp_valid)) chk8(p0_oe ? p0_out : 8'hxx, wd);
		end while (rsp_valid !== 1'b1 && cyc < 20);
		// A fetch answers two periods after its bus cycle, once the pin byte has crossed both stages.
		chkc(cyc, k == KIND_FETCH ? FETCH_CYCLES + 2 : DATA_CYCLES);
		chkc(n_ps, k == KIND_FETCH ? FETCH_STROBE_CYCLES : 0);
		chkc(n_rd, k == KIND_READ ? DATA_STROBE_CYCLES : 0);
		chkc(n_wr, k == KIND_WRITE ? DATA_STROBE_CYCLES : 0);
		chkc(n_ale, 1);
		chkc(n_fill, 1);
		if (k == KIND_WRITE) ref_mem[ea] = wd;
		else chk8(rsp_data, exp);
		for (cyc = 0; cyc < 8 && req_ready !== 1'b1; cyc++) @(negedge clk);
	endtask : do_op

	// Free-running clock at 100 MHz.
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Cuts a hang short well beyond the length of the whole run.
	initial
	begin
		repeat (20000) @(posedge clk);
		n_errors++;
		complete_run();
	end

	// ---------------------------------------------------------------
	// Main sequence.
	// ---------------------------------------------------------------
	initial
	begin
		seed = 32'h0c5d0f47;
		sys_rst = 1'b1; req_valid = 1'b0; req_kind = KIND_FETCH; req_data_pointer = 1'b0; req_addr = 16'h0000;
		req_wdata = 8'h00; p2_latch = 8'h12; latch_strobe_enable = 1'b0; external_code_select_n = 1'b1;
		repeat (16) @(negedge clk);
		sys_rst = 1'b0;
		chk8({4'h0, program_store_strobe_n_n, rd_n, wr_n, ale}, 8'h0e);
		// Internal code selected: a fetch is refused and the latch strobe stays gated off.
		req_valid = 1'b1;
		repeat (6)
		begin
			@(negedge clk);
			chk8({5'h00, req_ready, program_store_strobe_n_n, ale}, 8'h06);
		end
		req_valid = 1'b0;
		$display("test refusal done");
		// Random mix; the small address pool makes reads hit earlier writes.
		repeat (60)
		begin
			r = $random(seed);
			external_code_select_n = r[0];
			latch_strobe_enable = r[1];
			p2_latch = 8'h12 | {7'h00, r[2]};
			repeat (3) @(negedge clk);
			r = $random(seed);
			do_op((r[17:16] == 2'd0 && !external_code_select_n) ? KIND_FETCH : r[18] ? KIND_WRITE : KIND_READ,
				r[19], 16'h1200 | (r[15:0] & 16'h0103), r[27:20]);
		end
		$display("test random traffic done");
		complete_run();
	end
endmodule : tb_ext_mem_bus

`default_nettype wire
